// ---- hdl/opdec_defines.svh ----
// Purpose: timing counts, opcode values and field positions for the opcode decoder
// Assumes: one CLK_SYS cycle stands for one processor clock state
// Notes:   definitions only
`ifndef OPDEC_DEFINES_SVH
`define OPDEC_DEFINES_SVH

// clock-state counts per instruction form
`define CYC_RET_FALSE 5'h06
`define CYC_RET_TRUE  5'h0c
`define CYC_RET_UNC   5'h0a
`define CYC_RESTART   5'h0c
`define CYC_PORT      5'h0a
`define CYC_INC_REG   5'h04
`define CYC_INC_MEM   5'h0a
`define CYC_PAIR      5'h06
`define CYC_DAD_HL    5'h0a
`define CYC_ALU_REG   5'h04
`define CYC_ALU_MEM   5'h07
`define CYC_ALU_IMM   5'h07
`define CYC_OTHER     5'h04

// fixed opcodes
`define OP_RET_UNC    8'hc9
`define OP_ADD_IMM    8'hc6
`define OP_ADC_IMM    8'hce
`define OP_SUB_IMM    8'hd6
`define OP_PORT_IN    8'hdb
`define OP_PORT_OUT   8'hd3
`define OP_MASK_SET   8'h30
`define OP_MASK_READ  8'h20

// selector codes and flag positions
`define SEL_MEM       3'h6
`define FLAG_Z        0
`define FLAG_C        1
`define FLAG_P        2
`define FLAG_S        3

// accumulator fields of the mask instructions
`define ACC_CLR75_BIT 4
`define ACC_MSE_BIT   3
`define MASK_RESET    3'h7

`endif

// ---- hdl/opdec_pkg.sv ----
// Purpose: types shared by the opcode decoder files
// Assumes: nothing
// Notes:   numbers live in opdec_defines.svh
package opdec_pkg;

  // decoded instruction classes
  typedef enum logic [4:0] {
    CLS_OTHER, CLS_RETURN_UNCOND, CLS_RETURN_COND, CLS_RESTART,
    CLS_PORT_IN, CLS_PORT_OUT, CLS_INC_REG, CLS_DEC_REG,
    CLS_INC_PAIR, CLS_DEC_PAIR, CLS_DOUBLE_ADD_HL,
    CLS_ADD, CLS_ADC, CLS_SUB, CLS_SUB_BORROW,
    CLS_ADD_IMM, CLS_ADC_IMM, CLS_SUB_IMM,
    CLS_MASK_SET, CLS_MASK_READ
  } instr_class_t;

  // one decoded opcode
  typedef struct packed {
    instr_class_t cls;
    logic [4:0]   cycles;
    logic [2:0]   src;
    logic [2:0]   dst;
    logic [1:0]   pair;
    logic         cond_true;
    logic         mem;
    logic         imm;
    logic         keep_flags;
    logic         carry_in;
  } decode_t;

endpackage

// ---- hdl/seq_if.sv ----
// Purpose: start and progress of one instruction's clock-state count
// Assumes: single clock domain
// Notes:   ctl side loads a length, cnt side counts it down
`timescale 1ns/1ps
interface seq_if;
  logic       start;
  logic [4:0] length;
  logic       busy;
  logic       done;

  modport ctl (output start, output length, input busy, input done);
  modport cnt (input start, input length, output busy, output done);
endinterface

// ---- hdl/seq_counter.sv ----
// Purpose: counts the clock states of the instruction in progress
// Assumes: length is never zero when start is high
// Notes:   done marks the last busy cycle; a new start may land on it
`timescale 1ns/1ps
module seq_counter (
  input wire logic clk,
  input wire logic rst_n,
  seq_if.cnt       seq
);
  logic [4:0] cnt_r;

  // load on start, then count down to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (seq.start) begin
      cnt_r <= seq.length;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // progress flags
  assign seq.busy = (cnt_r != 5'h00);
  assign seq.done = (cnt_r == 5'h01);
endmodule

// ---- hdl/pin_sync2.sv ----
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   only the second flop is visible
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // two stages, cleared at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// ---- hdl/cpu_opcode_decode_arith_ctl.sv ----
// Purpose: decodes return, restart, port, inc/dec, add, subtract and mask opcodes
// Assumes: OP_BYTE, ACC_IN, FLAGS_IN, IE_IN come from logic on CLK_SYS
// Notes:   INT_PIN is asynchronous and synchronised here
// Contract
// - conditional return lasts 6 states if false, 12 if taken
// - conditional return is 11CCC000 with eight flag conditions
// - three-bit selectors: B C D E H L memory A, codes 0 to 7
// - pair increment 00PP0011, pairs BC DE HL SP, 6 states, flags kept
// - pair decrement 00PP1011, same pairs, 6 states
// - 00PP1001 adds pair into HL in 10 states
// - add and add-with-carry register forms take 4 states
// - add forms with source 110 read memory at HL, 7 states
// - add immediate and with carry fetch a byte, 7 states
// - subtract and with-borrow register forms take 4 states
// - subtract forms with source 110 use memory at HL, 7 states
// - subtract immediate fetches next byte, 7 states
// - mask-set instruction updates mask logic from accumulator
// - bit 4 clears 7.5 latch, bit 3 enables loading bits 2..0
// - mask-read returns pendings 6..4, enable bit 3, masks 2..0
`timescale 1ns/1ps
`include "opdec_defines.svh"
module cpu_opcode_decode_arith_ctl
  import opdec_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        OP_VALID,
  input  wire logic [7:0]  OP_BYTE,
  input  wire logic [7:0]  ACC_IN,
  input  wire logic [3:0]  FLAGS_IN,
  input  wire logic        IE_IN,
  input  wire logic [2:0]  INT_PIN,
  output logic             OP_READY,
  output logic             BUSY,
  output logic             INSTR_DONE,
  output logic [4:0]       INSTR_CLASS,
  output logic [4:0]       CYCLES,
  output logic [2:0]       SRC_SEL,
  output logic [2:0]       DST_SEL,
  output logic [1:0]       PAIR_SEL,
  output logic             COND_TAKEN,
  output logic             MEM_OPERAND,
  output logic             NEEDS_IMM,
  output logic             KEEP_FLAGS,
  output logic             USE_CARRY,
  output logic [15:0]      RST_VECTOR,
  output logic [7:0]       RIM_DATA,
  output logic [2:0]       INT_MASK,
  output logic [2:0]       INT_PEND
);

  seq_if       seq ();
  decode_t     dec_c;
  decode_t     dec_r;
  logic        take;
  logic [15:0] rst_vec_r;
  logic [2:0]  mask_r;
  logic        latch75_r;
  logic        prev75_r;
  logic        rise75;
  logic [2:0]  pin_q;
  logic [7:0]  rim_r;
  logic [2:0]  pend;

  // combinational decode of one opcode byte
  function automatic decode_t decode_op(input logic [7:0] op, input logic [3:0] fl);
    decode_t d;
    logic    f;
    d        = '0;
    d.cls    = CLS_OTHER;
    d.cycles = `CYC_OTHER;
    d.src    = op[2:0];
    d.dst    = op[5:3];
    d.pair   = op[5:4];
    case (op[5:4])
      2'h0:    f = fl[`FLAG_Z];
      2'h1:    f = fl[`FLAG_C];
      2'h2:    f = fl[`FLAG_P];
      default: f = fl[`FLAG_S];
    endcase
    casez (op)
      `OP_RET_UNC: begin
        d.cls    = CLS_RETURN_UNCOND;
        d.cycles = `CYC_RET_UNC;
      end
      8'b11??_?000: begin
        d.cls       = CLS_RETURN_COND;
        d.cond_true = op[3] ? f : !f;
        d.cycles    = d.cond_true ? `CYC_RET_TRUE : `CYC_RET_FALSE;
      end
      8'b11??_?111: begin
        d.cls    = CLS_RESTART;
        d.cycles = `CYC_RESTART;
      end
      `OP_PORT_IN, `OP_PORT_OUT: begin
        d.cls    = (op == `OP_PORT_IN) ? CLS_PORT_IN : CLS_PORT_OUT;
        d.cycles = `CYC_PORT;
        d.imm    = 1'b1;
      end
      `OP_MASK_SET: begin
        d.cls = CLS_MASK_SET;
      end
      `OP_MASK_READ: begin
        d.cls = CLS_MASK_READ;
      end
      8'b00??_?10?: begin
        d.cls    = op[0] ? CLS_DEC_REG : CLS_INC_REG;
        d.mem    = (op[5:3] == `SEL_MEM);
        d.cycles = d.mem ? `CYC_INC_MEM : `CYC_INC_REG;
      end
      8'b00??_0011: begin
        d.cls        = CLS_INC_PAIR;
        d.cycles     = `CYC_PAIR;
        d.keep_flags = 1'b1;
      end
      8'b00??_1011: begin
        d.cls        = CLS_DEC_PAIR;
        d.cycles     = `CYC_PAIR;
        d.keep_flags = 1'b1;
      end
      8'b00??_1001: begin
        d.cls    = CLS_DOUBLE_ADD_HL;
        d.cycles = `CYC_DAD_HL;
      end
      8'b1000_????: begin
        d.cls      = op[3] ? CLS_ADC : CLS_ADD;
        d.carry_in = op[3];
        d.mem      = (op[2:0] == `SEL_MEM);
        d.cycles   = d.mem ? `CYC_ALU_MEM : `CYC_ALU_REG;
      end
      8'b1001_????: begin
        d.cls      = op[3] ? CLS_SUB_BORROW : CLS_SUB;
        d.carry_in = op[3];
        d.mem      = (op[2:0] == `SEL_MEM);
        d.cycles   = d.mem ? `CYC_ALU_MEM : `CYC_ALU_REG;
      end
      `OP_ADD_IMM, `OP_ADC_IMM: begin
        d.cls      = op[3] ? CLS_ADC_IMM : CLS_ADD_IMM;
        d.carry_in = op[3];
        d.imm      = 1'b1;
        d.cycles   = `CYC_ALU_IMM;
      end
      `OP_SUB_IMM: begin
        d.cls    = CLS_SUB_IMM;
        d.imm    = 1'b1;
        d.cycles = `CYC_ALU_IMM;
      end
      default: d.cls = CLS_OTHER;
    endcase
    return d;
  endfunction

  assign dec_c = decode_op(OP_BYTE, FLAGS_IN);

  // handshake: accept when idle or in the last state of the current one
  assign OP_READY   = !seq.busy || seq.done;
  assign take       = OP_VALID && OP_READY;
  assign seq.start  = take;
  assign seq.length = dec_c.cycles;
  assign BUSY       = seq.busy;
  assign INSTR_DONE = seq.done;

  seq_counter u_seq (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .seq   (seq.cnt)
  );

  // interrupt pins: [2] level 7.5, [1] level 6.5, [0] level 5.5
  pin_sync2 #(.W(3)) u_pin_sync (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .d     (INT_PIN),
    .q     (pin_q)
  );

  // hold the decode of the instruction in progress
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      dec_r     <= '0;
      rst_vec_r <= 16'h0000;
    end else if (take) begin
      dec_r     <= dec_c;
      // restart target is field times eight
      rst_vec_r <= {10'h000, OP_BYTE[5:3], 3'h0};
    end
  end

  // masks load only with the enable bit set
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mask_r <= `MASK_RESET;
    end else if (take && dec_c.cls == CLS_MASK_SET && ACC_IN[`ACC_MSE_BIT]) begin
      mask_r <= ACC_IN[2:0];
    end
  end

  // level 7.5 edge latch, a new edge wins over the clear
  assign rise75 = pin_q[2] && !prev75_r;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      prev75_r  <= 1'b0;
      latch75_r <= 1'b0;
    end else begin
      prev75_r <= pin_q[2];
      if (rise75) begin
        latch75_r <= 1'b1;
      // accumulator bit 4 clears the latch
      end else if (take && dec_c.cls == CLS_MASK_SET && ACC_IN[`ACC_CLR75_BIT]) begin
        latch75_r <= 1'b0;
      end
    end
  end

  assign pend = {latch75_r, pin_q[1], pin_q[0]};

  // status image for the mask-read instruction
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rim_r <= 8'h00;
    end else if (take && dec_c.cls == CLS_MASK_READ) begin
      rim_r <= {1'b0, pend, IE_IN, mask_r};
    end
  end

  // outputs from registers
  assign INSTR_CLASS = dec_r.cls;
  assign CYCLES      = dec_r.cycles;
  assign SRC_SEL     = dec_r.src;
  assign DST_SEL     = dec_r.dst;
  assign PAIR_SEL    = dec_r.pair;
  assign COND_TAKEN  = dec_r.cond_true;
  assign MEM_OPERAND = dec_r.mem;
  assign NEEDS_IMM   = dec_r.imm;
  assign KEEP_FLAGS  = dec_r.keep_flags;
  assign USE_CARRY   = dec_r.carry_in;
  assign RST_VECTOR  = rst_vec_r;
  assign RIM_DATA    = rim_r;
  assign INT_MASK    = mask_r;
  assign INT_PEND    = pend;

  // helper: busy states counted since the last accepted opcode
  logic [4:0] since_r;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      since_r <= 5'h00;
    end else if (take) begin
      since_r <= 5'h01;
    end else if (seq.busy) begin
      since_r <= since_r + 5'h01;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence s_mask_load;
    take && dec_c.cls == CLS_MASK_SET && ACC_IN[`ACC_MSE_BIT];
  endsequence
  sequence s_clear75;
    take && dec_c.cls == CLS_MASK_SET && ACC_IN[`ACC_CLR75_BIT] && !rise75;
  endsequence

  chk_done_length: assert property (INSTR_DONE |-> since_r == CYCLES)
    else $error("done not at decoded length");
  chk_ret_zero_cond: assert property (take && OP_BYTE == 8'hc8 |=>
    COND_TAKEN == $past(FLAGS_IN[`FLAG_Z]) && CYCLES == (COND_TAKEN ? 5'h0c : 5'h06))
    else $error("return on zero wrong");
  chk_ret_plus_cond: assert property (take && OP_BYTE == 8'hf0 |=>
    COND_TAKEN == !$past(FLAGS_IN[`FLAG_S]) && CYCLES == (COND_TAKEN ? 5'h0c : 5'h06))
    else $error("return on positive wrong");
  chk_alu_src_sel: assert property (take && OP_BYTE[7:6] == 2'b10 |=>
    SRC_SEL == $past(OP_BYTE[2:0]) && MEM_OPERAND == ($past(OP_BYTE[2:0]) == 3'h6))
    else $error("source selector wrong");
  chk_pair_inc: assert property (take && OP_BYTE[7:6] == 2'b00 && OP_BYTE[3:0] == 4'h3 |=>
    INSTR_CLASS == CLS_INC_PAIR && CYCLES == 5'h06 && KEEP_FLAGS && PAIR_SEL == $past(OP_BYTE[5:4]))
    else $error("pair increment wrong");
  chk_pair_dec: assert property (take && OP_BYTE[7:6] == 2'b00 && OP_BYTE[3:0] == 4'hb |=>
    INSTR_CLASS == CLS_DEC_PAIR && CYCLES == 5'h06 ##5 INSTR_DONE)
    else $error("pair decrement wrong");
  chk_hl_add: assert property (take && OP_BYTE[7:6] == 2'b00 && OP_BYTE[3:0] == 4'h9 |=>
    INSTR_CLASS == CLS_DOUBLE_ADD_HL ##8 since_r == 5'h09 && !INSTR_DONE ##1 INSTR_DONE)
    else $error("hl add wrong");
  chk_add_cycles: assert property (take && OP_BYTE[7:4] == 4'h8 |=>
    CYCLES == (MEM_OPERAND ? 5'h07 : 5'h04) && USE_CARRY == $past(OP_BYTE[3]))
    else $error("add length wrong");
  chk_add_mem: assert property (take && OP_BYTE == 8'h8e |=> MEM_OPERAND && CYCLES == 5'h07)
    else $error("add memory wrong");
  chk_add_imm: assert property (take && (OP_BYTE == 8'hc6 || OP_BYTE == 8'hce) |=>
    NEEDS_IMM && CYCLES == 5'h07 && !MEM_OPERAND)
    else $error("add immediate wrong");
  chk_sub_cycles: assert property (take && OP_BYTE[7:4] == 4'h9 && OP_BYTE[2:0] != 3'h6 |=>
    CYCLES == 5'h04 ##3 INSTR_DONE)
    else $error("subtract length wrong");
  chk_sub_mem: assert property (take && OP_BYTE == 8'h9e |=>
    INSTR_CLASS == CLS_SUB_BORROW && MEM_OPERAND && CYCLES == 5'h07)
    else $error("subtract memory wrong");
  chk_sub_imm: assert property (take && OP_BYTE == 8'hd6 |=>
    INSTR_CLASS == CLS_SUB_IMM && NEEDS_IMM && CYCLES == 5'h07)
    else $error("subtract immediate wrong");
  chk_mask_load: assert property (s_mask_load |=> INT_MASK == $past(ACC_IN[2:0]))
    else $error("mask not loaded");
  chk_mask_hold: assert property (take && dec_c.cls == CLS_MASK_SET && !ACC_IN[3] |=>
    $stable(INT_MASK))
    else $error("mask changed without enable");
  chk_latch_clear: assert property (s_clear75 |=> !latch75_r)
    else $error("level 7.5 latch not cleared");
  chk_rim_image: assert property (take && dec_c.cls == CLS_MASK_READ |=>
    RIM_DATA == {1'b0, $past(pend), $past(IE_IN), $past(mask_r)})
    else $error("mask read image wrong");
  chk_restart_vec: assert property (take && OP_BYTE[7:6] == 2'b11 && OP_BYTE[2:0] == 3'h7 |=>
    RST_VECTOR == {10'h000, $past(OP_BYTE[5:3]), 3'h0} && CYCLES == 5'h0c)
    else $error("restart wrong");
  chk_inc_mem: assert property (take && OP_BYTE == 8'h34 |=>
    INSTR_CLASS == CLS_INC_REG && MEM_OPERAND && CYCLES == 5'h0a)
    else $error("memory increment wrong");
  chk_port_len: assert property (take && (OP_BYTE == 8'hdb || OP_BYTE == 8'hd3) |=>
    NEEDS_IMM && CYCLES == 5'h0a)
    else $error("port transfer wrong");

endmodule

// ---- tb/int_line_model.sv ----
// Purpose: drives the three interrupt request lines of the decoder
// Assumes: requests change on the bench clock's falling edge
// Notes:   lines lag requests by 13 ns so they change out of phase with CLK_SYS
`timescale 1ns/1ps
module int_line_model (
  input  wire logic [2:0] want,
  output logic      [2:0] pins
);
  // all lines idle low until a request arrives
  initial begin
    pins = 3'h0;
  end

  // each line follows its request after a fixed lag, like an outside device
  always @(want) begin
    pins <= #13 want;
  end
endmodule

// ---- tb/cpu_opcode_decode_arith_ctl_test.sv ----
// Purpose: self-checking bench for the opcode decoder
// Assumes: one CLK_SYS cycle is one clock state; inputs move on the falling edge
// Notes:   opcodes go back to back with a refused byte held during busy, apart from idle gaps at the pin and reset steps
`timescale 1ns/1ps
module cpu_opcode_decode_arith_ctl_test;
  import opdec_pkg::*;

  typedef struct {
    logic [7:0]   op;
    instr_class_t cls;
    logic [4:0]   cyc;
    logic [4:0]   bits;
  } row_t;

  logic        clk_sys;
  logic        rstn;
  logic        op_valid;
  logic [7:0]  op_byte;
  logic [7:0]  acc_in;
  logic [3:0]  flags_in;
  logic        ie_in;
  logic [2:0]  want;
  logic [2:0]  int_pin;
  logic        op_ready;
  logic        busy;
  logic        instr_done;
  logic [4:0]  instr_class;
  logic [4:0]  cycles;
  logic [2:0]  src_sel;
  logic [2:0]  dst_sel;
  logic [1:0]  pair_sel;
  logic        cond_taken;
  logic        mem_operand;
  logic        needs_imm;
  logic        keep_flags;
  logic        use_carry;
  logic [15:0] rst_vector;
  logic [7:0]  rim_data;
  logic [2:0]  int_mask;
  logic [2:0]  int_pend;
  int          error_cnt;
  int          cmp_count;
  int          cycle_cnt;

  // fixed opcodes: bits are {cond, mem, imm, keep, carry}
  row_t rows [0:10] = '{
    '{8'hc9, CLS_RETURN_UNCOND, 5'h0a, 5'h00},
    '{8'hc7, CLS_RESTART,       5'h0c, 5'h00},
    '{8'hef, CLS_RESTART,       5'h0c, 5'h00},
    '{8'hff, CLS_RESTART,       5'h0c, 5'h00},
    '{8'hdb, CLS_PORT_IN,       5'h0a, 5'h04},
    '{8'hd3, CLS_PORT_OUT,      5'h0a, 5'h04},
    '{8'hc6, CLS_ADD_IMM,       5'h07, 5'h04},
    '{8'hce, CLS_ADC_IMM,       5'h07, 5'h05},
    '{8'hd6, CLS_SUB_IMM,       5'h07, 5'h04},
    '{8'h00, CLS_OTHER,         5'h04, 5'h00},
    '{8'h20, CLS_MASK_READ,     5'h04, 5'h00}
  };

  cpu_opcode_decode_arith_ctl cpu_opcode_decode_arith_ctl_inst (
    .CLK_SYS     (clk_sys),
    .RSTN        (rstn),
    .OP_VALID    (op_valid),
    .OP_BYTE     (op_byte),
    .ACC_IN      (acc_in),
    .FLAGS_IN    (flags_in),
    .IE_IN       (ie_in),
    .INT_PIN     (int_pin),
    .OP_READY    (op_ready),
    .BUSY        (busy),
    .INSTR_DONE  (instr_done),
    .INSTR_CLASS (instr_class),
    .CYCLES      (cycles),
    .SRC_SEL     (src_sel),
    .DST_SEL     (dst_sel),
    .PAIR_SEL    (pair_sel),
    .COND_TAKEN  (cond_taken),
    .MEM_OPERAND (mem_operand),
    .NEEDS_IMM   (needs_imm),
    .KEEP_FLAGS  (keep_flags),
    .USE_CARRY   (use_carry),
    .RST_VECTOR  (rst_vector),
    .RIM_DATA    (rim_data),
    .INT_MASK    (int_mask),
    .INT_PEND    (int_pend)
  );

  int_line_model int_line_model_inst (
    .want (want),
    .pins (int_pin)
  );

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // counts and verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // issue one opcode at a falling edge, hold a refused byte while busy,
  // return at the falling edge of the last state so the next take chains on
  task automatic run_op(input logic [7:0] op, input logic [3:0] fl, input logic [4:0] cls,
                        input logic [4:0] cyc, input logic [4:0] bits);
    int n;
    op_valid = 1'b1;
    op_byte  = op;
    flags_in = fl;
    check(op_ready, 1'b1);
    @(posedge clk_sys);
    @(negedge clk_sys);
    op_byte  = ~op;
    flags_in = ~fl;
    n = 1;
    check(instr_class, cls);
    check(cycles, cyc);
    check({cond_taken, mem_operand, needs_imm, keep_flags, use_carry}, bits);
    check(src_sel, op[2:0]);
    check(dst_sel, op[5:3]);
    check(pair_sel, op[5:4]);
    check(rst_vector, {10'h000, op[5:3], 3'h0});
    check({busy, op_ready}, 2'h2);
    while (instr_done !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(n), cyc);
    check(instr_class, cls);
  endtask

  initial begin
    logic [3:0] fl;
    rstn     = 1'b0;
    op_valid = 1'b0;
    op_byte  = 8'h00;
    acc_in   = 8'h00;
    flags_in = 4'h0;
    ie_in    = 1'b0;
    want     = 3'h0;
    repeat (12) @(negedge clk_sys);
    check({busy, instr_done, op_ready, instr_class}, 8'h20);
    check({int_mask, int_pend, rim_data}, 14'h3800);
    rstn = 1'b1;
    for (int i = 0; i < 11; i++) begin
      run_op(rows[i].op, 4'h0, 5'(rows[i].cls), rows[i].cyc, rows[i].bits);
    end
    // conditional returns: chosen flag alone, others opposite
    for (int cc = 0; cc < 8; cc++) begin
      fl = 4'h1 << cc[2:1];
      run_op({2'h3, cc[2:0], 3'h0}, cc[0] ? fl : ~fl, CLS_RETURN_COND, 5'h0c, 5'h10);
      run_op({2'h3, cc[2:0], 3'h0}, cc[0] ? ~fl : fl, CLS_RETURN_COND, 5'h06, 5'h00);
    end
    // single register inc and dec over every selector
    for (int k = 0; k < 16; k++) begin
      run_op({2'h0, k[3:1], 2'h2, k[0]}, 4'h0, k[0] ? CLS_DEC_REG : CLS_INC_REG,
             (k[3:1] == 3'h6) ? 5'h0a : 5'h04, (k[3:1] == 3'h6) ? 5'h08 : 5'h00);
    end
    // pair increment, decrement and add to HL over every pair
    for (int p = 0; p < 4; p++) begin
      run_op({2'h0, p[1:0], 4'h3}, 4'h0, CLS_INC_PAIR, 5'h06, 5'h02);
      run_op({2'h0, p[1:0], 4'hb}, 4'h0, CLS_DEC_PAIR, 5'h06, 5'h02);
      run_op({2'h0, p[1:0], 4'h9}, 4'h0, CLS_DOUBLE_ADD_HL, 5'h0a, 5'h00);
    end
    // add, adc, sub, sbb over every source
    for (int k = 0; k < 32; k++) begin
      run_op({3'h4, k[4:0]}, 4'h0, 5'(CLS_ADD) + 5'(k[4:3]), (k[2:0] == 3'h6) ? 5'h07 : 5'h04,
             {1'b0, k[2:0] == 3'h6, 2'h0, k[3]});
    end
    // mask set loads only with the load-enable bit
    acc_in = 8'h0d;
    run_op(8'h30, 4'h0, CLS_MASK_SET, 5'h04, 5'h00);
    check(int_mask, 3'h5);
    acc_in = 8'h02;
    run_op(8'h30, 4'h0, CLS_MASK_SET, 5'h04, 5'h00);
    check(int_mask, 3'h5);
    op_valid = 1'b0;
    // short pulse on the 7.5 line is latched, 6.5 follows its level
    want = 3'h6;
    repeat (2) @(negedge clk_sys);
    want = 3'h2;
    repeat (4) @(negedge clk_sys);
    check(int_pend, 3'h6);
    ie_in = 1'b1;
    run_op(8'h20, 4'h0, CLS_MASK_READ, 5'h04, 5'h00);
    check(rim_data, 8'h6d);
    acc_in = 8'h18;
    run_op(8'h30, 4'h0, CLS_MASK_SET, 5'h04, 5'h00);
    check({int_mask, int_pend}, 6'h02);
    ie_in = 1'b0;
    run_op(8'h20, 4'h0, CLS_MASK_READ, 5'h04, 5'h00);
    check(rim_data, 8'h20);
    op_valid = 1'b0;
    @(negedge clk_sys);
    check({busy, op_ready}, 2'h1);
    // reset in the middle of a port instruction
    op_valid = 1'b1;
    op_byte  = 8'hdb;
    @(negedge clk_sys);
    op_valid = 1'b0;
    @(negedge clk_sys);
    rstn = 1'b0;
    #1;
    check({busy, op_ready, instr_class, int_mask}, 10'h107);
    @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    run_op(8'hd3, 4'h0, CLS_PORT_OUT, 5'h0a, 5'h04);
    op_valid = 1'b0;
    @(negedge clk_sys);
    close_out();
  end
endmodule
